/* logic/ormx_pkg.sv */
// Package: opcodes, field positions, reset values and timing for the OR/move/multiply executor
package ormx_pkg;
	// ----------------------------------------------------------------
	// Opcode prefixes (upper bits of the instruction word)
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_OR_LITERAL = 8'h09;
	localparam logic [7:0] OP_LITERAL_TO_BANK = 8'h01;
	localparam logic [7:0] OP_LITERAL_TO_ACC = 8'h0e;
	localparam logic [7:0] OP_MULTIPLY_LITERAL = 8'h0d;
	localparam logic [5:0] OP_OR_FILE = 6'h04;
	localparam logic [5:0] OP_MOVE_FILE = 6'h14;
	localparam logic [5:0] OP_INC_SKIP_NZ = 6'h12;
	localparam logic [6:0] OP_ACC_TO_FILE = 7'h37;
	localparam logic [3:0] OP_F2F_FIRST = 4'hc;
	localparam logic [3:0] OP_F2F_SECOND = 4'hf;
	localparam logic [9:0] OP_LOAD_POINTER = 10'h3b8;
	localparam logic [7:0] OP_SECOND_WORD = 8'hf0;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DEST_BIT = 9;
	localparam int ACCESS_BIT = 8;
	// ----------------------------------------------------------------
	// Addressing and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5f;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [11:0] ACC_ADDR = 12'hfe8;
	localparam logic [11:0] PROGRAM_COUNTER_LOW_ADDR = 12'hff9;
	localparam logic [11:0] STACK_TOP_LOW_ADDR = 12'hffd;
	localparam logic [11:0] STACK_TOP_HIGH_ADDR = 12'hffe;
	localparam logic [11:0] STACK_TOP_UPPER_ADDR = 12'hfff;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] BANK_RESET = 8'h00;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam int PHASES_PER_CYCLE = 4;
	typedef enum logic [3:0] {
		ORMX_NONE, ORMX_OR_LIT, ORMX_OR_FILE, ORMX_MOVE_FILE, ORMX_LIT_BANK, ORMX_LIT_ACC,
		ORMX_ACC_FILE, ORMX_MUL_LIT, ORMX_LOAD_PTR, ORMX_F2F, ORMX_INC_SKIP
	} ormx_op_type;
endpackage

/* logic/ormx_mem_if.sv */
// Interface: data memory port between the executor and its operand address unit
`timescale 1ns/1ns
interface ormx_mem_if;
	logic [7:0] file_field;
	logic access_bit;
	logic [7:0] bank_select_reg;
	logic ext_set_en;
	logic [7:0] pointer2_low;
	logic [11:0] addr;
	logic indexed;
	modport exec(output file_field, access_bit, bank_select_reg, ext_set_en, pointer2_low, input addr, indexed);
	modport unit(input file_field, access_bit, bank_select_reg, ext_set_en, pointer2_low, output addr, indexed);
endinterface

/* logic/ormx_addr_unit.sv */
// Module: forms the 12-bit data address of a byte-oriented file operand
`timescale 1ns/1ns
module ormx_addr_unit
	import ormx_pkg::*;
(
	ormx_mem_if.unit mem
);
	always_comb begin
		mem.indexed = 1'b0;
		if (mem.access_bit) begin
			mem.addr = {mem.bank_select_reg[3:0], mem.file_field}; // RQ4 RQ8
		end else if (mem.ext_set_en && mem.file_field <= INDEXED_LIMIT) begin
			// Offset added to the low byte of pointer 2, kept within bank 0 to stay single cycle
			mem.addr = {4'h0, 8'(mem.pointer2_low + mem.file_field)}; // RQ5
			mem.indexed = 1'b1;
		end else if (mem.file_field <= ACCESS_LOW_LIMIT) begin
			mem.addr = {4'h0, mem.file_field}; // RQ4
		end else begin
			mem.addr = {ACCESS_HIGH_BANK, mem.file_field}; // RQ4
		end
	end
endmodule // ormx_addr_unit

/* logic/ormx_exec.sv */
// Module: decode and execute of OR, move, load-pointer, multiply and skip tail
// Functional notes
// RQ1: OR literal with accumulator, result to accumulator, one word one cycle.
// RQ2: OR file with accumulator; destination bit picks accumulator or file.
// RQ3: ORs and move-file update only negative and zero flags.
// RQ4: Access bit 0 selects access bank; 1 uses bank select register.
// RQ5: Extended set and access 0: operands up to 5Fh use indexed addressing.
// RQ6: Load pointer: two words, high part first cycle, low byte second.
// RQ7: Move file copies to accumulator or back into the same register.
// RQ8: Single-word moves reach any byte of the selected 256-byte bank.
// RQ9: File-to-file move: prefix 1100 source word, prefix 1111 destination word.
// RQ10: File-to-file reads source in first word, writes destination in second.
// RQ11: Software never targets program counter low or stack top bytes.
// RQ12: Literal to bank select register; bits 7 to 4 stay zero.
// RQ13: Literal to accumulator, one cycle, flags unchanged.
// RQ14: Accumulator to file, one cycle, flags unchanged.
// RQ15: Unsigned accumulator times literal into product pair; accumulator kept.
// RQ16: Multiply touches no status flag.
// RQ17: Nonzero increment result discards the fetched instruction as a no-op.
// RQ18: Skip over a two-word instruction gives two no-op cycles.
// RQ19: Decode phase one, read two, process three, write four.
`timescale 1ns/1ns
module ormx_exec
	import ormx_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// Fetch pipeline
	input wire logic [1:0] i_phase,
	input wire logic [15:0] i_instr,
	input wire logic i_ext_set_en,
	// Data memory
	input wire logic [7:0] i_mem_rdata,
	output logic [11:0] o_mem_addr,
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic [7:0] o_mem_wdata,
	// Core state
	output logic [7:0] o_acc,
	output logic [7:0] o_bank_select_reg,
	output logic o_flag_neg,
	output logic o_flag_zero,
	output logic [7:0] o_product_high_byte,
	output logic [7:0] o_product_low_byte,
	output logic [7:0] o_pointer_high_byte [3],
	output logic [7:0] o_pointer_low_byte [3],
	output logic o_nop_cycle,
	output logic o_dest_illegal
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ORMX_FIRST, ORMX_SECOND, ORMX_SKIP1, ORMX_SKIP2} ormx_seq_type;
	ormx_seq_type seq, next_seq;
	ormx_op_type op, next_op;
	logic [7:0] acc, next_acc, bank_select_reg, next_bank_select_reg;
	logic [7:0] product_high_byte, next_product_high_byte, product_low_byte, next_product_low_byte;
	logic neg, next_neg, zero, next_zero;
	logic [7:0] ptr_hi [3], next_ptr_hi [3], ptr_lo [3], next_ptr_lo [3];
	logic [15:0] ir, next_ir;
	logic [7:0] opnd, next_opnd, res, next_res;
	logic [1:0] ptr_sel, next_ptr_sel;
	logic wr_dest_file, next_wr_dest_file;
	logic [11:0] addr;
	logic rd, wr;
	logic [7:0] wdata;
	logic [15:0] product;
	logic [7:0] inc_val;
	ormx_mem_if mem();
	ormx_addr_unit u_addr (.mem(mem));
	assign mem.file_field = ir[7:0];
	assign mem.access_bit = ir[ACCESS_BIT];
	assign mem.bank_select_reg = bank_select_reg;
	assign mem.ext_set_en = i_ext_set_en;
	assign mem.pointer2_low = ptr_lo[2];
	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	function automatic ormx_op_type decode_op(input logic [15:0] w);
		if (w[15:8] == OP_OR_LITERAL) return ORMX_OR_LIT;
		if (w[15:8] == OP_LITERAL_TO_BANK) return ORMX_LIT_BANK;
		if (w[15:8] == OP_LITERAL_TO_ACC) return ORMX_LIT_ACC;
		if (w[15:8] == OP_MULTIPLY_LITERAL) return ORMX_MUL_LIT;
		if (w[15:10] == OP_OR_FILE) return ORMX_OR_FILE;
		if (w[15:10] == OP_MOVE_FILE) return ORMX_MOVE_FILE;
		if (w[15:10] == OP_INC_SKIP_NZ) return ORMX_INC_SKIP;
		if (w[15:9] == OP_ACC_TO_FILE) return ORMX_ACC_FILE;
		if (w[15:12] == OP_F2F_FIRST) return ORMX_F2F;
		if (w[15:6] == OP_LOAD_POINTER) return ORMX_LOAD_PTR;
		return ORMX_NONE;
	endfunction
	function automatic logic is_two_word(input logic [15:0] w);
		return decode_op(w) == ORMX_F2F || decode_op(w) == ORMX_LOAD_PTR;
	endfunction
	assign product = {8'h00, acc} * {8'h00, ir[7:0]}; // RQ15
	assign inc_val = 8'(opnd + 8'h01);
	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_seq = seq;
		next_op = op;
		next_acc = acc;
		next_bank_select_reg = bank_select_reg;
		next_product_high_byte = product_high_byte;
		next_product_low_byte = product_low_byte;
		next_neg = neg;
		next_zero = zero;
		next_ptr_hi = ptr_hi;
		next_ptr_lo = ptr_lo;
		next_ir = ir;
		next_opnd = opnd;
		next_res = res;
		next_ptr_sel = ptr_sel;
		next_wr_dest_file = wr_dest_file;
		addr = 12'h000;
		rd = 1'b0;
		wr = 1'b0;
		wdata = res;
		case (seq)
			ORMX_FIRST: begin
				case (i_phase)
					2'd0: begin
						next_ir = i_instr; // RQ19
						next_op = decode_op(i_instr);
					end
					2'd1: begin
						if (op == ORMX_F2F) begin
							addr = ir[11:0]; // RQ9 RQ10
							rd = 1'b1;
						end else if (op inside {ORMX_OR_FILE, ORMX_MOVE_FILE, ORMX_INC_SKIP}) begin
							addr = mem.addr; // RQ19
							rd = 1'b1;
						end
						if (rd) begin
							next_opnd = (addr == ACC_ADDR) ? acc : i_mem_rdata; // RQ10
						end else begin
							next_opnd = ir[7:0];
						end
					end
					2'd2: begin
						next_wr_dest_file = ir[DEST_BIT];
						case (op)
							ORMX_OR_LIT, ORMX_OR_FILE: next_res = acc | opnd; // RQ1 RQ2
							ORMX_MOVE_FILE: next_res = opnd; // RQ7
							ORMX_INC_SKIP: next_res = inc_val;
							ORMX_ACC_FILE: next_res = acc; // RQ14
							ORMX_LOAD_PTR: next_ptr_sel = ir[5:4];
							default: next_res = opnd;
						endcase
						if (op == ORMX_OR_LIT) next_wr_dest_file = 1'b0;
					end
					default: begin
						case (op)
							ORMX_OR_LIT, ORMX_OR_FILE, ORMX_MOVE_FILE: begin
								next_neg = res[7]; // RQ3
								next_zero = res == 8'h00; // RQ3
								if (wr_dest_file) begin
									addr = mem.addr; // RQ2 RQ7 RQ8
									wr = 1'b1;
								end else begin
									next_acc = res; // RQ1 RQ2 RQ7
								end
							end
							ORMX_LIT_ACC: next_acc = opnd; // RQ13
							ORMX_LIT_BANK: next_bank_select_reg = {4'h0, opnd[3:0]}; // RQ12
							ORMX_ACC_FILE: begin
								addr = mem.addr; // RQ14 RQ8
								wr = 1'b1;
							end
							ORMX_MUL_LIT: begin
								next_product_high_byte = product[15:8]; // RQ15 RQ16
								next_product_low_byte = product[7:0];
							end
							ORMX_INC_SKIP: begin
								if (wr_dest_file) begin
									addr = mem.addr;
									wr = 1'b1;
								end else begin
									next_acc = res;
								end
								if (res != 8'h00) next_seq = ORMX_SKIP1; // RQ17
							end
							ORMX_LOAD_PTR: begin
								next_ptr_hi[ptr_sel] = {4'h0, ir[3:0]}; // RQ6
								next_seq = ORMX_SECOND;
							end
							ORMX_F2F: next_seq = ORMX_SECOND; // RQ10
							default: ;
						endcase
					end
				endcase
			end
			ORMX_SECOND: begin
				if (i_phase == 2'd0) next_ir = i_instr;
				if (i_phase == PHASE_LAST) begin
					next_seq = ORMX_FIRST;
					if (op == ORMX_LOAD_PTR) begin
						next_ptr_lo[ptr_sel] = ir[7:0]; // RQ6
					end else if (ir[15:12] == OP_F2F_SECOND) begin
						addr = ir[11:0]; // RQ9 RQ10
						wr = 1'b1;
						wdata = opnd;
						if (addr == ACC_ADDR) begin
							wr = 1'b0;
							next_acc = opnd; // RQ10
						end
					end
				end
			end
			ORMX_SKIP1: begin
				if (i_phase == 2'd0) next_ir = i_instr;
				// Fetched word is flushed; a two-word one costs a second flushed cycle
				if (i_phase == PHASE_LAST) next_seq = is_two_word(ir) ? ORMX_SKIP2 : ORMX_FIRST; // RQ18
			end
			ORMX_SKIP2: begin
				if (i_phase == PHASE_LAST) next_seq = ORMX_FIRST; // RQ18
			end
			default: next_seq = ORMX_FIRST;
		endcase
	end
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			seq <= ORMX_FIRST;
			op <= ORMX_NONE;
			acc <= ACC_RESET;
			bank_select_reg <= BANK_RESET;
			product_high_byte <= 8'h00;
			product_low_byte <= 8'h00;
			neg <= 1'b0;
			zero <= 1'b0;
			ptr_hi <= '{default: 8'h00};
			ptr_lo <= '{default: 8'h00};
			ir <= 16'h0000;
			opnd <= 8'h00;
			res <= 8'h00;
			ptr_sel <= 2'h0;
			wr_dest_file <= 1'b0;
		end else begin
			seq <= next_seq;
			op <= next_op;
			acc <= next_acc;
			bank_select_reg <= next_bank_select_reg;
			product_high_byte <= next_product_high_byte;
			product_low_byte <= next_product_low_byte;
			neg <= next_neg;
			zero <= next_zero;
			ptr_hi <= next_ptr_hi;
			ptr_lo <= next_ptr_lo;
			ir <= next_ir;
			opnd <= next_opnd;
			res <= next_res;
			ptr_sel <= next_ptr_sel;
			wr_dest_file <= next_wr_dest_file;
		end
	end
	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_mem_addr = addr;
	assign o_mem_rd = rd;
	assign o_mem_wr = wr;
	assign o_mem_wdata = wdata;
	assign o_acc = acc;
	assign o_bank_select_reg = bank_select_reg;
	assign o_flag_neg = neg;
	assign o_flag_zero = zero;
	assign o_product_high_byte = product_high_byte;
	assign o_product_low_byte = product_low_byte;
	assign o_pointer_high_byte = ptr_hi;
	assign o_pointer_low_byte = ptr_lo;
	assign o_nop_cycle = seq == ORMX_SKIP1 || seq == ORMX_SKIP2;
	// Forbidden destination of a file-to-file second word is flagged, not blocked; the write still happens
	assign o_dest_illegal = wr && seq == ORMX_SECOND
		&& (addr == PROGRAM_COUNTER_LOW_ADDR || addr == STACK_TOP_LOW_ADDR || addr == STACK_TOP_HIGH_ADDR
		|| addr == STACK_TOP_UPPER_ADDR); // RQ11
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_bank_upper_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst) bank_select_reg[7:4] == 4'h0) // RQ12
		else $error("bank select upper bits set");
	a_mul_keeps_acc: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RQ15 RQ16
		(seq == ORMX_FIRST && op == ORMX_MUL_LIT && i_phase == PHASE_LAST) |=> $stable(acc) && $stable(neg)
		&& product_high_byte == $past(product[15:8]))
		else $error("multiply changed accumulator or flags");
	a_or_lit_result: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RQ1 RQ3
		(seq == ORMX_FIRST && op == ORMX_OR_LIT && i_phase == PHASE_LAST) |=> acc == $past(res)
		&& zero == ($past(res) == 8'h00))
		else $error("or literal result wrong");
	a_lit_acc_flags: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RQ13
		(seq == ORMX_FIRST && op == ORMX_LIT_ACC && i_phase == PHASE_LAST) |=> $stable(zero) && $stable(neg))
		else $error("literal move touched flags");
	a_skip_one_cycle: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RQ17
		(seq == ORMX_FIRST && op == ORMX_INC_SKIP && i_phase == PHASE_LAST && res != 8'h00) |=> o_nop_cycle[*4])
		else $error("skip no-op cycle missing");
	a_writes_phase_four: assert property (@(posedge i_mclk) disable iff (i_sys_rst) wr |-> i_phase == PHASE_LAST) // RQ19
		else $error("write outside phase four");
	a_reads_phase_two: assert property (@(posedge i_mclk) disable iff (i_sys_rst) rd |-> i_phase == 2'd1) // RQ19
		else $error("read outside phase two");
	a_ptr_two_cycles: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RQ6
		(seq == ORMX_FIRST && op == ORMX_LOAD_PTR && i_phase == PHASE_LAST) |=> (seq == ORMX_SECOND) [*4])
		else $error("load pointer not two cycles");
	a_acc_file_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RQ14
		(seq == ORMX_FIRST && op == ORMX_ACC_FILE && i_phase == PHASE_LAST) |-> wr && wdata == acc)
		else $error("accumulator store missing");
	a_indexed_window: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // RQ5
		(rd && op != ORMX_F2F && i_ext_set_en && !ir[ACCESS_BIT] && ir[7:0] <= INDEXED_LIMIT) |-> mem.indexed)
		else $error("indexed addressing not selected");
	c_skip: cover property (@(posedge i_mclk) seq == ORMX_SKIP2);
	c_f2f: cover property (@(posedge i_mclk) seq == ORMX_SECOND && op == ORMX_F2F && wr);
	c_mul: cover property (@(posedge i_mclk) op == ORMX_MUL_LIT && i_phase == PHASE_LAST);
endmodule // ormx_exec

/* test/ormx_exec_tb.sv */
// Testbench: instruction sequences driven into the OR/move/multiply executor with expected results
`timescale 1ns/1ns
module tb;
	import ormx_pkg::*;
	// ----------------------------------------------------------------
	// Design hookup
	// ----------------------------------------------------------------
	logic i_mclk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [1:0] i_phase = 2'h0;
	logic [15:0] i_instr = 16'h0000;
	logic i_ext_set_en = 1'b0;
	logic [7:0] i_mem_rdata;
	logic [11:0] o_mem_addr;
	logic o_mem_rd, o_mem_wr, o_flag_neg, o_flag_zero, o_nop_cycle, o_dest_illegal;
	logic [7:0] o_mem_wdata, o_acc, o_bank_select_reg, o_product_high_byte, o_product_low_byte;
	logic [7:0] o_pointer_high_byte [3];
	logic [7:0] o_pointer_low_byte [3];
	logic [7:0] mem [4096];
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int nops = 0;
	int reads = 0;
	logic seen_ill = 1'b0;
	ormx_exec dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_phase(i_phase), .i_instr(i_instr),
		.i_ext_set_en(i_ext_set_en), .i_mem_rdata(i_mem_rdata), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
		.o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_acc(o_acc), .o_bank_select_reg(o_bank_select_reg),
		.o_flag_neg(o_flag_neg), .o_flag_zero(o_flag_zero), .o_product_high_byte(o_product_high_byte),
		.o_product_low_byte(o_product_low_byte), .o_pointer_high_byte(o_pointer_high_byte),
		.o_pointer_low_byte(o_pointer_low_byte), .o_nop_cycle(o_nop_cycle), .o_dest_illegal(o_dest_illegal));
	// ----------------------------------------------------------------
	// Clock, data memory and monitors
	// ----------------------------------------------------------------
	initial begin
		forever #20 i_mclk = ~i_mclk;
	end
	// Read data follows the address at once, as the executor expects
	assign i_mem_rdata = mem[o_mem_addr];
	always @(posedge i_mclk) begin
		if (o_mem_wr === 1'b1) mem[o_mem_addr] <= o_mem_wdata;
		if (o_nop_cycle === 1'b1) nops++;
		if (o_mem_rd === 1'b1) reads++;
		if (o_dest_illegal === 1'b1) seen_ill = 1'b1;
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			test_done();
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One instruction cycle: word shown at phase 0, results settled after the phase 3 edge
	task automatic run(input logic [15:0] w);
		for (int p = 0; p < 4; p++) begin
			@(negedge i_mclk);
			i_phase = p[1:0];
			if (p == 0) i_instr = w;
		end
		@(posedge i_mclk);
		#1;
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		repeat (2) @(negedge i_mclk);
		i_sys_rst = 1'b0;
		#1;
		chk("acc", 16'h0000, 16'(o_acc));
		chk("bank", 16'h0000, 16'(o_bank_select_reg));
		chk("flags", 16'h0000, 16'({o_flag_neg, o_flag_zero}));
		run(16'h0e9a);
		chk("acc", 16'h009a, 16'(o_acc));
		run(16'h0935);
		chk("acc", 16'h00bf, 16'(o_acc));
		chk("neg zero", 16'h0002, 16'({o_flag_neg, o_flag_zero}));
		reads = 0;
		run(16'h01f5);
		chk("bank", 16'h0005, 16'(o_bank_select_reg));
		mem[12'h520] = 8'h40;
		run(16'h1320);
		chk("file 520", 16'h00ff, 16'(mem[12'h520]));
		chk("acc", 16'h00bf, 16'(o_acc));
		chk("reads", 16'h0001, 16'(reads));
		run(16'h0e00);
		chk("neg zero", 16'h0002, 16'({o_flag_neg, o_flag_zero}));
		run(16'h5010);
		chk("neg zero", 16'h0001, 16'({o_flag_neg, o_flag_zero}));
		mem[12'hf80] = 8'h81;
		run(16'h1080);
		chk("acc", 16'h0081, 16'(o_acc));
		chk("neg zero", 16'h0002, 16'({o_flag_neg, o_flag_zero}));
		run(16'h53ff);
		chk("neg zero", 16'h0001, 16'({o_flag_neg, o_flag_zero}));
		run(16'h6fff);
		chk("file 5ff", 16'h0081, 16'(mem[12'h5ff]));
		chk("neg zero", 16'h0001, 16'({o_flag_neg, o_flag_zero}));
		// Pointer 2 later serves as the base of the indexed access
		run(16'hee23);
		chk("ptr2 first", 16'h0300, 16'({o_pointer_high_byte[2], o_pointer_low_byte[2]}));
		run(16'hf0ab);
		chk("ptr2", 16'h03ab, 16'({o_pointer_high_byte[2], o_pointer_low_byte[2]}));
		run(16'hee1f);
		run(16'hf0ff);
		chk("ptr1", 16'h0fff, 16'({o_pointer_high_byte[1], o_pointer_low_byte[1]}));
		i_ext_set_en = 1'b1;
		mem[12'h0bb] = 8'h77;
		run(16'h5010);
		chk("acc indexed", 16'h0077, 16'(o_acc));
		run(16'h5080);
		chk("acc above window", 16'h0081, 16'(o_acc));
		i_ext_set_en = 1'b0;
		run(16'h0ee2);
		run(16'h0900);
		run(16'h0dc4);
		chk("product", 16'had08, 16'({o_product_high_byte, o_product_low_byte}));
		chk("acc", 16'h00e2, 16'(o_acc));
		run(16'h0d00);
		chk("product", 16'h0000, 16'({o_product_high_byte, o_product_low_byte}));
		chk("neg zero", 16'h0002, 16'({o_flag_neg, o_flag_zero}));
		mem[12'h123] = 8'h33;
		mem[12'h456] = 8'h11;
		run(16'hc123);
		chk("dest early", 16'h0011, 16'(mem[12'h456]));
		run(16'hf456);
		chk("dest", 16'h0033, 16'(mem[12'h456]));
		chk("illegal", 16'h0000, 16'(seen_ill));
		run(16'hc123);
		run(16'hfff9);
		chk("illegal", 16'h0001, 16'(seen_ill));
		// Accumulator as source, then as destination
		run(16'hcfe8);
		run(16'hf456);
		chk("acc to 456", 16'h00e2, 16'(mem[12'h456]));
		run(16'hc123);
		run(16'hffe8);
		chk("acc from 123", 16'h0033, 16'(o_acc));
		// Nonzero increment: the following literal load must be flushed
		mem[12'h030] = 8'h05;
		nops = 0;
		run(16'h4a30);
		run(16'h0e11);
		chk("inc", 16'h0006, 16'(mem[12'h030]));
		chk("acc", 16'h0033, 16'(o_acc));
		chk("nop clocks", 16'h0004, 16'(nops));
		mem[12'h030] = 8'hff;
		run(16'h4830);
		chk("inc to acc", 16'h0000, 16'(o_acc));
		nops = 0;
		run(16'h0e11);
		chk("acc", 16'h0011, 16'(o_acc));
		chk("nop clocks", 16'h0000, 16'(nops));
		mem[12'h030] = 8'h01;
		nops = 0;
		run(16'h4a30);
		run(16'hee01);
		run(16'hf0cd);
		chk("ptr0", 16'h0000, 16'({o_pointer_high_byte[0], o_pointer_low_byte[0]}));
		chk("nop clocks", 16'h0008, 16'(nops));
		run(16'h0e22);
		chk("acc", 16'h0022, 16'(o_acc));
		test_done();
	end
endmodule // tb
